// *** logic/mfs_pkg.sv ***
// mfs_pkg: constants and carrier types for the motor fault supervisor
// assumes a 10 MHz core clock and synchronous active-high reset
`default_nettype none
package mfs_pkg;
    localparam int unsigned CLK_HZ = 10_000_000;
    localparam int unsigned CP_START_US = 250;
    localparam int unsigned CP_START_CYC = (CP_START_US * (CLK_HZ / 1_000_000));
    localparam int unsigned POR_HOLD_MS = 100;
    localparam int unsigned POR_HOLD_CYC = POR_HOLD_MS * (CLK_HZ / 1000);
    localparam int unsigned WDT_TICK_MS = 32;
    localparam int unsigned WDT_TICK_CYC = WDT_TICK_MS * (CLK_HZ / 1000);
    localparam int unsigned OPEN_BASE_MS = 1;
    localparam int unsigned OPEN_BASE_CYC = OPEN_BASE_MS * (CLK_HZ / 1000);
    localparam int CNT_W = 24;
    localparam logic [1:0] TR_RANGE1 = 2'h0;
    localparam logic [1:0] TR_RANGE2 = 2'h1;
    localparam logic [1:0] TR_RANGE3 = 2'h2;
    localparam logic [1:0] TR_WARN = 2'h3;
    localparam int NCOIL = 2;
    localparam int NDRV = 4;
    localparam int NSYNC = 8;

    // comparator inputs, raw from the analog side
    typedef struct packed {
        logic above_t1;
        logic above_t2;
        logic above_warn;
        logic above_tsd;
        logic [NDRV-1:0] ovc;
        logic uv_low;
        logic uv_high;
        logic ov_high;
        logic ov_low;
    } mfs_cmp_t;

    // latched fault flags
    typedef struct packed {
        logic [NDRV-1:0] ovc;
        logic [NCOIL-1:0] open_coil;
        logic pump_fault;
    } mfs_flags_t;

    typedef enum logic [1:0] {
        MFS_WD_POR = 2'b00,
        MFS_WD_RUN = 2'b01,
        MFS_WD_FIRE = 2'b11
    } mfs_wd_state_t;
endpackage : mfs_pkg
`default_nettype wire

// *** logic/mfs_sync2.sv ***
// mfs_sync2: two-flop resynchroniser per bit
// assumes inputs are slow analog comparator levels
`default_nettype none
module mfs_sync2 #(
    parameter int W = 1
) (
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    logic [W-1:0] meta_r;
    logic [W-1:0] sync_r;

    genvar g;
    generate
        for (g = 0; g < W; g++)
        begin : g_bit
            always_ff @(posedge clock_i)
            begin
                if (rst_i)
                begin
                    meta_r[g] <= 1'b0;
                    sync_r[g] <= 1'b0;
                end
                else
                begin
                    meta_r[g] <= d_i[g];
                    sync_r[g] <= meta_r[g];
                end
            end
        end
    endgenerate

    assign q_o = sync_r;
endmodule // mfs_sync2
`default_nettype wire

// *** logic/mfs_open_det.sv ***
// mfs_open_det: per-coil full-duty timer for open coil detection
// assumes duty_full_i is synchronous to clock_i
`default_nettype none
module mfs_open_det (
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic run_i,
    input wire logic [1:0] open_time_i,
    input wire logic duty_full_i,
    output logic hit_o
);
    logic [mfs_pkg::CNT_W-1:0] cnt_r;
    logic [mfs_pkg::CNT_W-1:0] cnt_nxt;
    logic [mfs_pkg::CNT_W-1:0] limit_w;

    // limit = base << field, 1/2/4/8 ms
    assign limit_w = mfs_pkg::CNT_W'(mfs_pkg::OPEN_BASE_CYC) << open_time_i;
    assign cnt_nxt = (run_i && duty_full_i && (cnt_r < limit_w)) ? cnt_r + 1'b1 : 
        ((run_i && duty_full_i) ? cnt_r : '0);
    assign hit_o = run_i && duty_full_i && (cnt_r >= limit_w);

    always_ff @(posedge clock_i)
    begin
        if (rst_i)
            cnt_r <= '0;
        else
            cnt_r <= cnt_nxt;
    end
endmodule // mfs_open_det
`default_nettype wire

// *** logic/mfs_supervisor.sv ***
// mfs_supervisor: sleep gating, thermal, fault latching, error and watchdog reset outputs
// assumes a serial register front end supplies control bits and read strobes
`default_nettype none
module mfs_supervisor #(
    parameter int unsigned POR_HOLD_CYCLES = mfs_pkg::POR_HOLD_CYC,
    parameter int unsigned CP_START_CYCLES = mfs_pkg::CP_START_CYC,
    parameter int unsigned WDT_TICK_CYCLES = mfs_pkg::WDT_TICK_CYC
) (
    input wire logic clock_i,
    input wire logic rst_i,
    input wire mfs_pkg::mfs_cmp_t cmp_i,
    input wire logic pump_ok_i,
    input wire logic [mfs_pkg::NCOIL-1:0] duty_full_i,
    input wire logic sleep_request_bit_i,
    input wire logic clear_pin_i,
    input wire logic motor_drive_enable_wr_i,
    input wire logic motor_drive_enable_val_i,
    input wire logic thermal_shutdown_clr_i,
    input wire logic [1:0] open_time_i,
    input wire logic watchdog_arm_wr_i,
    input wire logic watchdog_arm_val_i,
    input wire logic [3:0] watchdog_limit_field_i,
    input wire logic output_type_select_i,
    input wire logic status_capture_i,
    input wire logic status_read_done_i,
    output logic [1:0] thermal_range_field_o,
    output logic thermal_shutdown_bit_o,
    output mfs_pkg::mfs_flags_t flags_o,
    output mfs_pkg::mfs_flags_t flags_snap_o,
    output logic motor_drive_enable_o,
    output logic bridge_drive_o,
    output logic core_clk_run_o,
    output logic digital_clear_o,
    output logic watchdog_fired_flag_o,
    output logic watchdog_arm_bit_o,
    output logic error_output_n_o,
    output logic error_output_n_oe_o,
    output logic watchdog_reset_out_n_o,
    output logic watchdog_reset_out_n_oe_o
);
    localparam int SW = mfs_pkg::NSYNC + mfs_pkg::NDRV;

    mfs_pkg::mfs_cmp_t cmp_s;
    mfs_pkg::mfs_flags_t flags_r;
    mfs_pkg::mfs_flags_t flags_nxt;
    mfs_pkg::mfs_flags_t snap_r;
    mfs_pkg::mfs_flags_t set_w;
    mfs_pkg::mfs_flags_t clr_w;
    mfs_pkg::mfs_wd_state_t wd_state_r;
    mfs_pkg::mfs_wd_state_t wd_state_nxt;
    logic tsd_r;
    logic uv_lock_r;
    logic ov_lock_r;
    logic motor_drive_enable_r;
    logic motor_drive_enable_nxt;
    logic wd_fired_r;
    logic wd_arm_r;
    logic cp_window_r;
    logic [mfs_pkg::CNT_W-1:0] cp_cnt_r;
    logic [mfs_pkg::CNT_W-1:0] hold_cnt_r;
    logic [mfs_pkg::CNT_W-1:0] tick_cnt_r;
    logic [3:0] wd_cnt_r;
    logic [1:0] tr_r;
    logic awake_w;
    logic tick_w;
    logic wd_hit_w;
    logic any_latched_w;
    logic block_w;
    logic tsd_set_w;
    logic err_w;
    logic [mfs_pkg::NCOIL-1:0] open_hit_w;
    logic [1:0] tr_w;

    // comparator resynchronisation
    mfs_sync2 #(.W(SW)) u_sync (
        .clock_i(clock_i),
        .rst_i(rst_i),
        .d_i(cmp_i),
        .q_o(cmp_s)
    );

    assign awake_w = !sleep_request_bit_i;
    assign core_clk_run_o = awake_w;
    assign digital_clear_o = clear_pin_i && awake_w;

    // thermal range encoding
    assign tr_w = cmp_s.above_warn ? mfs_pkg::TR_WARN :
        (cmp_s.above_t2 ? mfs_pkg::TR_RANGE3 :
        (cmp_s.above_t1 ? mfs_pkg::TR_RANGE2 : mfs_pkg::TR_RANGE1));

    genvar c;
    generate
        for (c = 0; c < mfs_pkg::NCOIL; c++)
        begin : g_coil
            mfs_open_det u_open (
                .clock_i(clock_i),
                .rst_i(rst_i),
                .run_i(awake_w && motor_drive_enable_r),
                .open_time_i(open_time_i),
                .duty_full_i(duty_full_i[c]),
                .hit_o(open_hit_w[c])
            );
        end
    endgenerate

    // fault sets: awake only, analog is off in sleep
    assign set_w.ovc = awake_w ? (cmp_s.ovc & {mfs_pkg::NDRV{motor_drive_enable_r}}) : '0;
    assign set_w.open_coil = awake_w ? open_hit_w : '0;
    assign set_w.pump_fault = awake_w && !pump_ok_i && !cp_window_r;
    // read clear only of captured flags, never in sleep
    assign clr_w = (status_read_done_i && awake_w) ? snap_r : '0;
    assign flags_nxt = set_w | (flags_r & ~clr_w); // set wins

    assign any_latched_w = |flags_r;
    assign tsd_set_w = awake_w && cmp_s.above_tsd;
    assign block_w = any_latched_w || tsd_r || uv_lock_r || ov_lock_r;
    assign motor_drive_enable_nxt = block_w || |set_w || tsd_set_w || !awake_w ? 1'b0 :
        (motor_drive_enable_wr_i ? motor_drive_enable_val_i : motor_drive_enable_r);
    assign err_w = any_latched_w || tsd_r || (tr_r == mfs_pkg::TR_WARN) ||
        (cp_window_r && !pump_ok_i);

    // watchdog tick and compare
    assign tick_w = (tick_cnt_r >= mfs_pkg::CNT_W'(WDT_TICK_CYCLES - 1));
    assign wd_hit_w = wd_arm_r && tick_w && (wd_cnt_r >= watchdog_limit_field_i);

    always_comb
    begin
        wd_state_nxt = wd_state_r;
        unique case (wd_state_r)
            mfs_pkg::MFS_WD_POR:
                if (hold_cnt_r >= mfs_pkg::CNT_W'(POR_HOLD_CYCLES - 1))
                    wd_state_nxt = mfs_pkg::MFS_WD_RUN;
            mfs_pkg::MFS_WD_RUN:
                if (wd_hit_w)
                    wd_state_nxt = mfs_pkg::MFS_WD_FIRE;
            mfs_pkg::MFS_WD_FIRE:
                if (hold_cnt_r >= mfs_pkg::CNT_W'(POR_HOLD_CYCLES - 1))
                    wd_state_nxt = mfs_pkg::MFS_WD_RUN;
            default:
                wd_state_nxt = mfs_pkg::MFS_WD_POR;
        endcase
    end

    always_ff @(posedge clock_i)
    begin
        if (rst_i)
        begin
            flags_r <= '0;
            snap_r <= '0;
            motor_drive_enable_r <= 1'b0;
            tr_r <= mfs_pkg::TR_RANGE1;
        end
        else
        begin
            flags_r <= flags_nxt;
            motor_drive_enable_r <= motor_drive_enable_nxt;
            if (status_capture_i)
                snap_r <= flags_r;
            if (awake_w)
                tr_r <= tr_w;
        end
    end

    // thermal shutdown latch, exit needs cool and clear
    always_ff @(posedge clock_i)
    begin
        if (rst_i)
            tsd_r <= 1'b0;
        else if (tsd_set_w)
            tsd_r <= 1'b1;
        else if (thermal_shutdown_clr_i && !cmp_s.above_warn)
            tsd_r <= 1'b0;
    end

    // supply lockouts with hysteresis
    always_ff @(posedge clock_i)
    begin
        if (rst_i)
        begin
            uv_lock_r <= 1'b0;
            ov_lock_r <= 1'b0;
        end
        else
        begin
            if (cmp_s.uv_low)
                uv_lock_r <= 1'b1;
            else if (cmp_s.uv_high)
                uv_lock_r <= 1'b0;
            if (cmp_s.ov_high)
                ov_lock_r <= 1'b1;
            else if (cmp_s.ov_low)
                ov_lock_r <= 1'b0;
        end
    end

    // charge pump start window after reset
    always_ff @(posedge clock_i)
    begin
        if (rst_i)
        begin
            cp_cnt_r <= '0;
            cp_window_r <= 1'b1;
        end
        else if (cp_window_r)
        begin
            cp_cnt_r <= cp_cnt_r + 1'b1;
            if (cp_cnt_r >= mfs_pkg::CNT_W'(CP_START_CYCLES - 1))
                cp_window_r <= 1'b0;
        end
    end

    // watchdog state, hold timer, counter and fired flag
    always_ff @(posedge clock_i)
    begin
        if (rst_i)
        begin
            wd_state_r <= mfs_pkg::MFS_WD_POR;
            hold_cnt_r <= '0;
            tick_cnt_r <= '0;
            wd_cnt_r <= '0;
            wd_arm_r <= 1'b0;
            wd_fired_r <= 1'b0;
        end
        else
        begin
            wd_state_r <= wd_state_nxt;
            hold_cnt_r <= (wd_state_nxt != wd_state_r || wd_state_r == mfs_pkg::MFS_WD_RUN) ?
                '0 : hold_cnt_r + 1'b1;
            if (watchdog_arm_wr_i)
            begin
                wd_arm_r <= watchdog_arm_val_i;
                tick_cnt_r <= '0;
                wd_cnt_r <= '0;
            end
            else if (wd_hit_w)
            begin
                wd_arm_r <= 1'b0;
                tick_cnt_r <= '0;
                wd_cnt_r <= '0;
                wd_fired_r <= 1'b1;
            end
            else if (wd_arm_r)
            begin
                tick_cnt_r <= tick_w ? '0 : tick_cnt_r + 1'b1;
                if (tick_w)
                    wd_cnt_r <= wd_cnt_r + 1'b1;
            end
        end
    end

    assign thermal_range_field_o = tr_r;
    assign thermal_shutdown_bit_o = tsd_r;
    assign flags_o = flags_r;
    assign flags_snap_o = snap_r;
    assign motor_drive_enable_o = motor_drive_enable_r;
    assign bridge_drive_o = motor_drive_enable_r && awake_w && !tsd_r && !uv_lock_r && !ov_lock_r;
    assign watchdog_fired_flag_o = wd_fired_r;
    assign watchdog_arm_bit_o = wd_arm_r;

    // open drain drives only low; push-pull drives always
    assign error_output_n_o = !err_w;
    assign error_output_n_oe_o = output_type_select_i || err_w;
    assign watchdog_reset_out_n_o = (wd_state_r == mfs_pkg::MFS_WD_RUN);
    assign watchdog_reset_out_n_oe_o = output_type_select_i ||
        (wd_state_r != mfs_pkg::MFS_WD_RUN);
endmodule // mfs_supervisor
`default_nettype wire

// *** verification/mfs_supervisor_checker.sv ***
// mfs_supervisor_checker: port-level properties of the fault supervisor
// assumes it is bound onto mfs_supervisor, one clock, synchronous reset
`default_nettype none
module mfs_supervisor_checker #(
    parameter int unsigned POR_HOLD_CYCLES = 20
) (
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic sleep_request_bit_i,
    input wire logic clear_pin_i,
    input wire logic status_read_done_i,
    input wire logic output_type_select_i,
    input wire logic [1:0] thermal_range_field_o,
    input wire logic thermal_shutdown_bit_o,
    input wire mfs_pkg::mfs_flags_t flags_o,
    input wire mfs_pkg::mfs_flags_t flags_snap_o,
    input wire logic motor_drive_enable_o,
    input wire logic bridge_drive_o,
    input wire logic core_clk_run_o,
    input wire logic digital_clear_o,
    input wire logic watchdog_fired_flag_o,
    input wire logic error_output_n_o,
    input wire logic error_output_n_oe_o,
    input wire logic watchdog_reset_out_n_o,
    input wire logic watchdog_reset_out_n_oe_o
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clock_i); endclocking
    default disable iff (rst_i);
    int unsigned hold_r;
    // cycles since reset release, saturating
    always_ff @(posedge clock_i)
    begin
        if (rst_i)
            hold_r <= 0;
        else if (hold_r < POR_HOLD_CYCLES)
            hold_r <= hold_r + 1;
    end
    property p_clk; core_clk_run_o == !sleep_request_bit_i; endproperty
    a_clk: assert property (p_clk) else $error("clock gate wrong");
    property p_clr; digital_clear_o == (clear_pin_i && !sleep_request_bit_i); endproperty
    a_clr: assert property (p_clr) else $error("clear pin not masked");
    property p_br; bridge_drive_o |-> motor_drive_enable_o && !thermal_shutdown_bit_o; endproperty
    a_br: assert property (p_br) else $error("bridge driven while off");
    property p_en; (|flags_o || thermal_shutdown_bit_o) |-> !motor_drive_enable_o; endproperty
    a_en: assert property (p_en) else $error("enable with fault");
    property p_err; (thermal_range_field_o == 2'h3 || thermal_shutdown_bit_o || |flags_o)
        |-> error_output_n_oe_o && !error_output_n_o; endproperty
    a_err: assert property (p_err) else $error("error pin not low");
    property p_keep; (!status_read_done_i || sleep_request_bit_i)
        |=> (flags_o & $past(flags_o)) == $past(flags_o); endproperty
    a_keep: assert property (p_keep) else $error("flag lost");
    property p_snap; status_read_done_i
        |=> ($past(flags_o) & ~$past(flags_snap_o) & ~flags_o) == 0; endproperty
    a_snap: assert property (p_snap) else $error("clear of unread flag");
    property p_por; hold_r < POR_HOLD_CYCLES |-> watchdog_reset_out_n_oe_o && !watchdog_reset_out_n_o; endproperty
    a_por: assert property (p_por) else $error("reset out released early");
    property p_fire; $rose(watchdog_fired_flag_o) |-> ##[0:1] !watchdog_reset_out_n_o; endproperty
    a_fire: assert property (p_fire) else $error("no reset on expiry");
    property p_od; !output_type_select_i |-> (!error_output_n_oe_o || !error_output_n_o)
        && (!watchdog_reset_out_n_oe_o || !watchdog_reset_out_n_o); endproperty
    a_od: assert property (p_od) else $error("open drain drove high");
endmodule // mfs_supervisor_checker
bind mfs_supervisor mfs_supervisor_checker #(.POR_HOLD_CYCLES(POR_HOLD_CYCLES)) u_chk (.*);
`default_nettype wire

// *** verification/mfs_mcu_model.sv ***
// mfs_mcu_model: controller strobes for status reads and watchdog re-arm
// assumes one-cycle requests from the bench
`default_nettype none
module mfs_mcu_model (
    input wire logic clock_i,
    input wire logic rd_go_i,
    input wire logic arm_go_i,
    output logic status_capture_o,
    output logic status_read_done_o,
    output logic watchdog_arm_wr_o,
    output logic watchdog_arm_val_o
);
    timeunit 1ns;
    timeprecision 1ns;
    initial
    begin
        {status_capture_o, status_read_done_o, watchdog_arm_wr_o, watchdog_arm_val_o} = 4'h0;
    end
    // capture strictly before the read completes
    always @(posedge clock_i)
    begin
        status_capture_o <= rd_go_i;
        status_read_done_o <= status_capture_o;
        watchdog_arm_wr_o <= arm_go_i;
        watchdog_arm_val_o <= arm_go_i;
    end
endmodule // mfs_mcu_model
`default_nettype wire

// *** verification/mfs_supervisor_test.sv ***
// mfs_supervisor_test: self-checking bench for the fault supervisor
// assumes mfs_pkg, design, checker and controller model compiled first
`default_nettype none
module mfs_supervisor_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic clock_i = 1'b0;
    logic rst_i = 1'b1;
    mfs_pkg::mfs_cmp_t cmp = 12'h0;
    mfs_pkg::mfs_flags_t flags, snap;
    logic pump_ok = 1'b0, sleep = 1'b0, clr_pin = 1'b0, en_wr = 1'b0, en_val = 1'b0, tsd_clr = 1'b0;
    logic ots = 1'b0, rd_go = 1'b0, arm_go = 1'b0, cap, done, arm_wr, arm_val;
    logic [1:0] duty = 2'h0, tr, open_t = 2'h0;
    logic [3:0] lim = 4'hF;
    logic thermal_shutdown_bit, en, bridge, clk_run, dclr, fired, arm_bit, err_n, err_oe, wd_n, wd_oe;
    int mismatches = 0, comparisons = 0, cyc = 0, n;
    logic [5:0] rows [4] = '{6'h01, 6'h23, 6'h35, 6'h3E};
    wire err_pin = (err_oe && !err_n) ? 1'b0 : 1'b1;
    wire wd_pin = (wd_oe && !wd_n) ? 1'b0 : 1'b1;
    mfs_supervisor #(.POR_HOLD_CYCLES(20), .CP_START_CYCLES(10), .WDT_TICK_CYCLES(4)) DUT (
        .clock_i(clock_i), .rst_i(rst_i), .cmp_i(cmp), .pump_ok_i(pump_ok), .duty_full_i(duty),
        .sleep_request_bit_i(sleep), .clear_pin_i(clr_pin), .motor_drive_enable_wr_i(en_wr),
        .motor_drive_enable_val_i(en_val), .thermal_shutdown_clr_i(tsd_clr), .open_time_i(open_t),
        .watchdog_arm_wr_i(arm_wr), .watchdog_arm_val_i(arm_val), .watchdog_limit_field_i(lim),
        .output_type_select_i(ots), .status_capture_i(cap), .status_read_done_i(done),
        .thermal_range_field_o(tr), .thermal_shutdown_bit_o(thermal_shutdown_bit), .flags_o(flags), .flags_snap_o(snap),
        .motor_drive_enable_o(en), .bridge_drive_o(bridge), .core_clk_run_o(clk_run),
        .digital_clear_o(dclr), .watchdog_fired_flag_o(fired), .watchdog_arm_bit_o(arm_bit),
        .error_output_n_o(err_n), .error_output_n_oe_o(err_oe), .watchdog_reset_out_n_o(wd_n),
        .watchdog_reset_out_n_oe_o(wd_oe));
    mfs_mcu_model u_mcu (.clock_i(clock_i), .rd_go_i(rd_go), .arm_go_i(arm_go), .status_capture_o(cap),
        .status_read_done_o(done), .watchdog_arm_wr_o(arm_wr), .watchdog_arm_val_o(arm_val));
    always #50 clock_i = ~clock_i;
    task automatic give_verdict();
        if (mismatches == 0 && comparisons > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    always @(posedge clock_i)
    begin
        cyc++;
        if (cyc == 40000)
        begin
            mismatches++;
            give_verdict();
        end
    end
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic step(input int c);
        repeat (c) @(posedge clock_i);
        #10;
    endtask
    task automatic wr_en(input logic v);
        en_wr = 1'b1;
        en_val = v;
        step(1);
        en_wr = 1'b0;
        step(1);
    endtask
    task automatic rd();
        rd_go = 1'b1;
        step(1);
        rd_go = 1'b0;
        step(4);
    endtask
    task automatic wait_for(input int lim_c);
        n = 0;
        while (!(flags.open_coil === 2'h2 || fired === 1'b1) && n < lim_c)
        begin
            step(1);
            n++;
        end
    endtask
    initial
    begin
        cmp.uv_high = 1'b1;
        cmp.ov_low = 1'b1;
        step(3);
        rst_i = 1'b0;
        chk(wd_pin, 1'b0);
        chk(fired, 1'b0);
        step(5);
        chk(err_pin, 1'b0);
        chk(flags.pump_fault, 1'b0);
        step(12);
        chk(flags.pump_fault, 1'b1);
        step(8);
        chk(wd_pin, 1'b1);
        pump_ok = 1'b1;
        rd();
        chk(flags.pump_fault, 1'b0);
        chk(err_oe, 1'b0);
        chk(snap, 7'h01);
        foreach (rows[i])
        begin
            {cmp.above_t1, cmp.above_t2, cmp.above_warn} = rows[i][5:3];
            step(4);
            chk(tr, rows[i][2:1]);
            chk(err_pin, rows[i][0]);
        end
        cmp.above_tsd = 1'b1;
        step(4);
        chk(thermal_shutdown_bit, 1'b1);
        chk(bridge, 1'b0);
        tsd_clr = 1'b1;
        step(1);
        tsd_clr = 1'b0;
        {cmp.above_t1, cmp.above_t2, cmp.above_warn, cmp.above_tsd} = 4'h0;
        step(4);
        chk(thermal_shutdown_bit, 1'b1);
        tsd_clr = 1'b1;
        step(1);
        tsd_clr = 1'b0;
        step(2);
        chk(thermal_shutdown_bit, 1'b0);
        wr_en(1'b1);
        chk(bridge, 1'b1);
        cmp.ovc = 4'h4;
        step(4);
        chk(flags.ovc, 4'h4);
        chk(en, 1'b0);
        chk(err_pin, 1'b0);
        cmp.ovc = 4'h0;
        wr_en(1'b1);
        chk(en, 1'b0);
        sleep = 1'b1;
        clr_pin = 1'b1;
        step(2);
        chk(clk_run, 1'b0);
        chk(dclr, 1'b0);
        rd();
        chk(flags.ovc, 4'h4);
        sleep = 1'b0;
        step(1);
        chk(dclr, 1'b1);
        clr_pin = 1'b0;
        rd();
        chk(flags.ovc, 4'h0);
        step(5);
        wr_en(1'b1);
        chk(en, 1'b1);
        cmp.uv_low = 1'b1;
        step(4);
        chk(en, 1'b0);
        {cmp.uv_low, cmp.uv_high} = 2'h0;
        wr_en(1'b1);
        chk(en, 1'b0);
        cmp.uv_high = 1'b1;
        step(4);
        wr_en(1'b1);
        chk(en, 1'b1);
        duty = 2'h2;
        wait_for(10100);
        chk(flags.open_coil, 2'h2);
        chk(n > 9900, 1'b1);
        chk(en, 1'b0);
        duty = 2'h0;
        rd();
        open_t = 2'h1;
        wr_en(1'b1);
        duty = 2'h2;
        wait_for(20100);
        chk(flags.open_coil, 2'h2);
        chk(n > 19900, 1'b1);
        duty = 2'h0;
        rd();
        ots = 1'b1;
        step(2);
        chk(err_oe, 1'b1);
        lim = 4'h3;
        repeat (6)
        begin
            arm_go = 1'b1;
            step(1);
            arm_go = 1'b0;
            step(7);
        end
        chk(fired, 1'b0);
        chk(arm_bit, 1'b1);
        wait_for(40);
        chk(fired, 1'b1);
        chk(wd_pin, 1'b0);
        step(18);
        chk(wd_pin, 1'b0);
        step(2);
        chk(wd_pin, 1'b1);
        give_verdict();
    end
endmodule // mfs_supervisor_test
`default_nettype wire
